// File: rtl/iopc_top.sv
`timescale 1ns/10ps
module iopc_top
  import iopc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic sync_n,
  input wire logic fifo_enabled,
  input wire logic data_ready,
  input wire logic fifo_irq,
  input wire logic clk_out_sel,
  input wire logic clk_out_level,
  input wire logic standby_indicator_en,
  input wire logic standby_level,
  output logic fifo_flush,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic dout_rdy_sel,
  output logic dout_rdy_level,
  output logic [2:0] gen_pin_out,
  output logic [2:0] gen_pin_oe,
  output logic irq
);

  // ********************************
  // Register state
  // ********************************
  logic [15:0] pin_function_control_r;
  logic [15:0] pin_function_control_nxt;
  logic [1:0] irq_status_r;
  logic [1:0] irq_status_nxt;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_mask_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic fifo_flush_r;
  logic fifo_flush_nxt;
  logic [2:0] pin_out_r;
  logic [2:0] pin_oe_r;
  logic clk_out_r;
  logic clk_oe_r;
  logic dout_sel_r;
  logic dout_lvl_r;

  iopc_cfg_s cfg;
  iopc_pins_s pins;
  logic sync_fall;
  logic irq_event;
  logic clk_irq_sel;
  logic dout_sel;

  // ********************************
  // Address decode
  // ********************************
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  assign hit_ctrl = (reg_addr == IOPC_ADDR_PIN_CTRL);
  assign hit_stat = (reg_addr == IOPC_ADDR_IRQ_STATUS);
  assign hit_mask = (reg_addr == IOPC_ADDR_IRQ_MASK);
  assign wr_ctrl = reg_write & hit_ctrl;
  assign wr_stat = reg_write & hit_stat;
  assign wr_mask = reg_write & hit_mask;

  // Reserved bits are never stored, so they always read as zero
  assign pin_function_control_nxt = wr_ctrl ? (reg_wdata & IOPC_PIN_CTRL_WMASK) : pin_function_control_r;
  assign irq_mask_nxt = wr_mask ? reg_wdata[1:0] : irq_mask_r;

  // ********************************
  // Function decode
  // ********************************
  assign cfg = iopc_decode(pin_function_control_r);

  // Data-ready when the FIFO is off, the FIFO condition otherwise
  assign irq_event = fifo_enabled ? fifo_irq : data_ready;

  iopc_sync_edge u_sync
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_n(sync_n),
    .fall_pulse(sync_fall)
  );

  iopc_pin_mux u_mux
  (
    .cfg(cfg),
    .irq_event(irq_event),
    .standby_indicator_en(standby_indicator_en),
    .standby_level(standby_level),
    .pins(pins),
    .clk_irq_sel(clk_irq_sel),
    .dout_rdy_sel(dout_sel)
  );

  assign fifo_flush_nxt = sync_fall & cfg.flush_en;

  // ********************************
  // Interrupt status
  // ********************************
  // New events win over a same-cycle write-one-to-clear
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set = {fifo_flush_nxt, sync_fall};
  assign irq_clr = wr_stat ? reg_wdata[1:0] : 2'h0;
  assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

  // ********************************
  // Read path
  // ********************************
  logic [15:0] read_word;
  assign read_word = hit_ctrl ? pin_function_control_r :
                     hit_stat ? {14'h0000, irq_status_r} :
                     hit_mask ? {14'h0000, irq_mask_r} : 16'h0000;
  assign rdata_nxt = reg_read ? read_word : 16'h0000;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pin_function_control_r <= IOPC_PIN_CTRL_RESET;
      irq_status_r <= IOPC_IRQ_RESET;
      irq_mask_r <= IOPC_IRQ_RESET;
      rdata_r <= 16'h0000;
      fifo_flush_r <= 1'b0;
    end
    else
    begin
      pin_function_control_r <= pin_function_control_nxt;
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r <= rdata_nxt;
      fifo_flush_r <= fifo_flush_nxt;
    end
  end

  // ********************************
  // Pin drivers
  // ********************************
  // Registered to keep pins glitch free; costs one cycle of latency
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pin_out_r <= 3'h0;
      pin_oe_r <= 3'h0;
      clk_out_r <= 1'b0;
      clk_oe_r <= 1'b0;
      dout_sel_r <= 1'b0;
      dout_lvl_r <= 1'b0;
    end
    else
    begin
      pin_out_r <= pins.out & pins.oe;
      pin_oe_r <= pins.oe;
      clk_out_r <= clk_irq_sel ? irq_event : clk_out_level;
      clk_oe_r <= clk_irq_sel | clk_out_sel;
      dout_sel_r <= dout_sel;
      dout_lvl_r <= dout_sel & data_ready;
    end
  end

  assign reg_rdata = rdata_r;
  assign fifo_flush = fifo_flush_r;
  assign gen_pin_out = pin_out_r;
  assign gen_pin_oe = pin_oe_r;
  assign clk_pin_out = clk_out_r;
  assign clk_pin_oe = clk_oe_r;
  assign dout_rdy_sel = dout_sel_r;
  assign dout_rdy_level = dout_lvl_r;
  assign irq = |(irq_status_r & irq_mask_r);

endmodule // iopc_top

// File: include/iopc_pkg.sv
package iopc_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] IOPC_ADDR_PIN_CTRL = 8'h03;
  localparam logic [7:0] IOPC_ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IOPC_ADDR_IRQ_MASK = 8'h11;
  localparam logic [15:0] IOPC_PIN_CTRL_RESET = 16'h0000;
  localparam logic [15:0] IOPC_PIN_CTRL_WMASK = 16'h07EE;
  localparam logic [1:0] IOPC_IRQ_RESET = 2'h0;

  // ********************************
  // Field positions
  // ********************************
  localparam int IOPC_BIT_FLUSH_EN = 10;
  localparam int IOPC_BIT_ROUTE_LO = 8;
  localparam int IOPC_BIT_LEVEL_LO = 5;
  localparam int IOPC_BIT_ENABLE_LO = 1;

  // Interrupt status bits
  localparam int IOPC_IRQ_SYNC = 0;
  localparam int IOPC_IRQ_FLUSH = 1;

  typedef enum logic [1:0] {
    IOPC_ROUTE_NONE = 2'b00,
    IOPC_ROUTE_CLK = 2'b01,
    IOPC_ROUTE_PIN0 = 2'b10,
    IOPC_ROUTE_DOUT = 2'b11
  } iopc_route_e;

  typedef struct packed {
    logic flush_en;
    iopc_route_e route;
    logic [2:0] level;
    logic [2:0] enable;
  } iopc_cfg_s;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } iopc_pins_s;

  function automatic iopc_cfg_s iopc_decode(input logic [15:0] word);
    iopc_cfg_s c;
    c.flush_en = word[IOPC_BIT_FLUSH_EN];
    c.route = iopc_route_e'(word[IOPC_BIT_ROUTE_LO +: 2]);
    c.level = word[IOPC_BIT_LEVEL_LO +: 3];
    c.enable = word[IOPC_BIT_ENABLE_LO +: 3];
    return c;
  endfunction

endpackage

// File: rtl/iopc_sync_edge.sv
`timescale 1ns/10ps
module iopc_sync_edge
  import iopc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pin_n,
  output logic fall_pulse
);

  logic meta_r;
  logic stable_r;
  logic prev_r;

  // ********************************
  // Two-stage synchroniser, then edge
  // ********************************
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      meta_r <= 1'b1;
      stable_r <= 1'b1;
      prev_r <= 1'b1;
    end
    else
    begin
      meta_r <= pin_n;
      stable_r <= meta_r;
      prev_r <= stable_r;
    end
  end

  assign fall_pulse = prev_r & ~stable_r;

endmodule // iopc_sync_edge

// File: rtl/iopc_pin_mux.sv
`timescale 1ns/10ps
module iopc_pin_mux
  import iopc_pkg::*;
(
  input iopc_cfg_s cfg,
  input wire logic irq_event,
  input wire logic standby_indicator_en,
  input wire logic standby_level,
  output iopc_pins_s pins,
  output logic clk_irq_sel,
  output logic dout_rdy_sel
);

  // ********************************
  // Per-pin priority selection
  // ********************************
  logic route_pin0;
  assign route_pin0 = (cfg.route == IOPC_ROUTE_PIN0);
  assign clk_irq_sel = (cfg.route == IOPC_ROUTE_CLK);
  assign dout_rdy_sel = (cfg.route == IOPC_ROUTE_DOUT);

  // Pin 2: standby indicator beats the general output
  assign pins.oe[2] = standby_indicator_en | cfg.enable[2];
  assign pins.out[2] = standby_indicator_en ? standby_level : cfg.level[2];
  assign pins.oe[1] = cfg.enable[1];
  assign pins.out[1] = cfg.level[1];
  // Pin 0: interrupt routing beats the general output
  assign pins.oe[0] = route_pin0 | cfg.enable[0];
  assign pins.out[0] = route_pin0 ? irq_event : cfg.level[0];

endmodule // iopc_pin_mux

// File: tb/iopc_props.sv
`timescale 1ns/10ps
module iopc_props
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic fifo_enabled,
  input wire logic data_ready,
  input wire logic fifo_irq,
  input wire logic standby_indicator_en,
  input wire logic standby_level,
  input wire logic fifo_flush,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic dout_rdy_level,
  input wire logic [2:0] gen_pin_out,
  input wire logic [2:0] gen_pin_oe,
  input wire logic irq
);
  // ****
  // Shadow of the pin control register
  // ****
  logic [15:0] cfg_r;
  logic live_r;
  wire ev = fifo_enabled ? fifo_irq : data_ready;
  // live_r keeps $past away from values taken during reset
  always_ff @(posedge ref_clk)
  begin
    live_r <= reset_n;
    if (!reset_n)
      cfg_r <= 16'h0000;
    else if (reg_write && reg_addr == 8'h03)
      cfg_r <= reg_wdata & 16'h07EE;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_rd_idle: assert property (live_r && !$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_rd_cfg: assert property (live_r && $past(reg_read && reg_addr == 8'h03) |-> reg_rdata == $past(cfg_r))
    else $error("control read wrong");
  a_clk_route: assert property (live_r && $past(cfg_r[9:8]) == 2'b01 |-> clk_pin_oe && clk_pin_out == $past(ev))
    else $error("clock pin route wrong");
  a_pin0_route: assert property (live_r && $past(cfg_r[9:8]) == 2'b10 |-> gen_pin_oe[0] && gen_pin_out[0] == $past(ev))
    else $error("pin 0 route wrong");
  a_dout_only: assert property (live_r |-> dout_rdy_level == ($past(data_ready) && $past(cfg_r[9:8]) == 2'b11))
    else $error("ready pin wrong");
  a_pin1_gate: assert property (live_r |-> gen_pin_oe[1] == $past(cfg_r[2]) && gen_pin_out[1] == $past(cfg_r[6] & cfg_r[2]))
    else $error("pin 1 wrong");
  a_pin2_stby: assert property (live_r && $past(standby_indicator_en) |-> gen_pin_oe[2] && gen_pin_out[2] == $past(standby_level))
    else $error("pin 2 standby wrong");
  a_flush_gate: assert property (fifo_flush |-> $past(cfg_r[10]) ##1 !fifo_flush)
    else $error("flush pulse wrong");
  cover property (fifo_flush);
  cover property (irq);
  cover property (dout_rdy_level);
  cover property (clk_pin_oe && clk_pin_out);
endmodule // iopc_props
bind iopc_top iopc_props iopc_props_inst (.*);

// File: tb/iopc_host_model.sv
`timescale 1ns/10ps
module iopc_host_model
(
  input wire logic ref_clk,
  input wire logic go,
  output logic sync_n
);
  // ****
  // Host side of the sync pin
  // ****
  int low_cnt = 0;
  initial sync_n = 1'b1;
  // Held low several cycles so the device synchroniser cannot miss it
  always @(posedge ref_clk)
  begin
    if (go)
      low_cnt <= 4;
    else if (low_cnt > 0)
      low_cnt <= low_cnt - 1;
    sync_n <= !(go || low_cnt > 1);
  end
endmodule // iopc_host_model

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
  // ****
  // Bench
  // ****
  logic ref_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, go = 1'b0;
  logic fifo_enabled = 1'b0, data_ready = 1'b0, fifo_irq = 1'b0, clk_out_sel = 1'b0;
  logic clk_out_level = 1'b0, standby_indicator_en = 1'b0, standby_level = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, cnt;
  logic sync_n, fifo_flush, clk_pin_out, clk_pin_oe, dout_rdy_sel, dout_rdy_level, irq;
  logic [2:0] gen_pin_out, gen_pin_oe;
  int fails = 0, n_compared = 0;
  wire [15:0] pv = {6'h0, clk_pin_oe, clk_pin_out, dout_rdy_sel, dout_rdy_level, gen_pin_oe, gen_pin_out};
  iopc_top iopc_top_inst (.*);
  iopc_host_model iopc_host_model_inst (.*);
  always #25 ref_clk = ~ref_clk;
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Pins lag the register by a cycle; realign to an edge afterwards
  task pchk(input logic [15:0] e);
    repeat (2) @(posedge ref_clk);
    #1 chk(pv, e);
    @(posedge ref_clk);
  endtask
  task sync_pulse;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    cnt = 16'h0000;
    repeat (12)
    begin
      @(posedge ref_clk);
      #1 cnt += fifo_flush;
    end
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h03, 16'h0000);
    chk(pv, 16'h0000);
    $display("end reset test");
    wr(8'h03, 16'hFFFF);
    clk_out_sel <= 1'b1;
    fifo_enabled <= 1'b1;
    fifo_irq <= 1'b1;
    rd(8'h03, 16'h07EE);
    rd(8'h04, 16'h0000);
    for (int r = 0; r < 4; r++)
    begin
      wr(8'h03, {6'h00, r[1:0], 8'h8E});
      pchk({6'h0, 1'b1, r == 1, r == 3, 1'b0, 5'b11110, r == 2});
    end
    data_ready <= 1'b1;
    fifo_enabled <= 1'b0;
    fifo_irq <= 1'b0;
    pchk(16'h02FC);
    wr(8'h03, 16'h018E);
    pchk(16'h033C);
    $display("end routing test");
    wr(8'h03, 16'h00E0);
    standby_indicator_en <= 1'b1;
    standby_level <= 1'b0;
    pchk(16'h0220);
    standby_indicator_en <= 1'b0;
    $display("end output test");
    wr(8'h11, 16'h0003);
    for (int f = 0; f < 2; f++)
    begin
      wr(8'h03, {5'h0, f[0], 10'h000});
      sync_pulse;
      chk(cnt, {15'h0, f[0]});
      chk({15'h0, irq}, 16'h0001);
      rd(8'h10, {14'h0, f[0], 1'b1});
      wr(8'h10, 16'h0003);
      rd(8'h10, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
    end
    wr(8'h11, 16'h0000);
    sync_pulse;
    chk({15'h0, irq}, 16'h0000);
    rd(8'h10, 16'h0003);
    $display("end sync test");
    report_and_stop;
  end
endmodule // tb
